//--- hw/dcd_debug_command_decoder.v
// debug command decoder: two-wire link receiver, command execution, configuration byte
// assumes link pins arrive asynchronously; cpu, flash and status signals share clk_sys
//
// What this block does
// - command byte: bits 7-3 code, bit 2 return byte, bits 1-0 arg count.
// - status-read command returns the single debug status byte when bit 2 is set, nothing otherwise.
// - code 0001 0x00 requests full flash mass erase and lock clear.
// - after any command other than status read, erase or an unknown code is accepted, later mass erases are refused.
// - code 0001 1x01 stores the following host byte as configuration.
// - code 0010 0100 returns configuration as last written.
// - code 0010 1000 returns 16-bit program counter, two bytes whenever unlocked.
// - code 0011 0x00 decodes as status-byte read.
// - code 0011 1x11 decodes as hardware breakpoint set.
// - code 0100 1100 resumes the processor; only while halted.
// - code 0101 01xx runs injected bytes while halted, pc unchanged.
// - code 0101 1100 steps one program instruction while halted, pc advances.
// - code 0110 01xx replaces next instruction while halted, pc advances.
// - code 0110 1000 returns 16-bit chip identity, two bytes always.
// - configuration bit 3 set disables all timers.
// - configuration bit 2 set pauses all dma transfers.
// - configuration bit 1 suspends timers in injected or stepped branch instructions.
// - configuration bit 0 selects flash information page, else main page.
// - configuration bits 7-4 ignored on write.
// - while locked only erase, status read and identity read execute.
// - status bits 7..0: erase done, idle, halted, pm0, cause, lock, osc, overflow.
`timescale 1ns/1ps
`default_nettype none
`include "dcd_map.vh"

module dcd_debug_command_decoder (
    input wire clk_sys,
    input wire sys_rst,
    input wire dbg_clk,
    input wire dbg_data_in,
    output wire dbg_data_out,
    output wire dbg_data_oe,
    input wire [15:0] cpu_pc,
    input wire [15:0] chip_identity,
    input wire erase_done,
    input wire cpu_idle,
    input wire cpu_halted,
    input wire power_mode_0,
    input wire halt_cause,
    input wire port_lock_bit,
    input wire osc_stable,
    input wire stack_overflow,
    output wire erase_req,
    output wire halt_req,
    output wire resume_req,
    output wire inject_req,
    output wire step_req,
    output wire replace_req,
    output wire breakpoint_req,
    output wire [23:0] cmd_arg,
    output wire [1:0] cmd_arg_count,
    output wire timers_off,
    output wire dma_pause,
    output wire timer_suspend,
    output wire sel_info_page
);

    localparam [2:0] ST_CMD = 3'd0;
    localparam [2:0] ST_ARG = 3'd1;
    localparam [2:0] ST_EXEC = 3'd2;
    localparam [2:0] ST_RET = 3'd3;

    function [3:0] dcd_decode;
        input [7:0] b;
        begin
            dcd_decode = `DCD_OP_NONE;
            if (b[7:3] == `DCD_PAT_ERASE && b[1:0] == 2'b00)
                dcd_decode = `DCD_OP_ERASE;
            else if (b[7:3] == `DCD_PAT_WRCFG && b[1:0] == 2'b01)
                dcd_decode = `DCD_OP_WRCFG;
            else if (b == `DCD_CODE_RDCFG)
                dcd_decode = `DCD_OP_RDCFG;
            else if (b == `DCD_CODE_PC)
                dcd_decode = `DCD_OP_PC;
            else if (b[7:3] == `DCD_PAT_STATUS && b[1:0] == 2'b00)
                dcd_decode = `DCD_OP_STATUS;
            else if (b[7:3] == `DCD_PAT_BRKPT && b[1:0] == 2'b11)
                dcd_decode = `DCD_OP_BRKPT;
            else if (b == `DCD_CODE_HALT)
                dcd_decode = `DCD_OP_HALT;
            else if (b == `DCD_CODE_RESUME)
                dcd_decode = `DCD_OP_RESUME;
            else if (b[7:2] == `DCD_PAT_INJECT)
                dcd_decode = `DCD_OP_INJECT;
            else if (b == `DCD_CODE_STEP)
                dcd_decode = `DCD_OP_STEP;
            else if (b[7:2] == `DCD_PAT_REPLACE)
                dcd_decode = `DCD_OP_REPLACE;
            else if (b == `DCD_CODE_IDENT)
                dcd_decode = `DCD_OP_IDENT;
        end
    endfunction

    // two-flop synchronisers, third stage only for edge finding
    reg clk_s1_q, clk_s2_q, clk_s3_q;
    reg dat_s1_q, dat_s2_q;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            dat_s1_q <= 1'b0;
            dat_s2_q <= 1'b0;
        end else begin
            clk_s1_q <= dbg_clk;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            dat_s1_q <= dbg_data_in;
            dat_s2_q <= dat_s1_q;
        end
    end

    wire link_rise = clk_s2_q & ~clk_s3_q;
    wire link_fall = ~clk_s2_q & clk_s3_q;

    reg [2:0] state_q;
    reg [2:0] bit_cnt_q;
    reg [7:0] rx_q;
    reg [7:0] cmd_q;
    reg [1:0] args_left_q;
    reg [23:0] arg_q;
    reg [15:0] tx_q;
    reg [4:0] ret_len_q;
    reg [4:0] sent_q;
    reg out_q, oe_q;
    reg [3:0] cfg_q;
    reg erase_allow_q;
    reg erase_q, halt_q, resume_q, inject_q, step_q, replace_q, brk_q;

    wire [7:0] rx_next = {rx_q[6:0], dat_s2_q};
    wire [3:0] op = dcd_decode(cmd_q);

    wire [7:0] status_byte = {erase_done, cpu_idle, cpu_halted, power_mode_0,
                              halt_cause, port_lock_bit, osc_stable, stack_overflow};

    wire lock_ok = ~port_lock_bit | (op == `DCD_OP_ERASE) | (op == `DCD_OP_STATUS) |
                   (op == `DCD_OP_IDENT);

    // link framing: host data sampled on falling edges, reply driven on rising edges
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= ST_CMD;
            bit_cnt_q <= 3'd0;
            rx_q <= 8'h00;
            cmd_q <= 8'h00;
            args_left_q <= 2'd0;
            arg_q <= 24'h000000;
            tx_q <= 16'h0000;
            ret_len_q <= 5'd0;
            sent_q <= 5'd0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
            cfg_q <= `DCD_CFG_RESET;
            erase_allow_q <= 1'b1;
            erase_q <= 1'b0;
            halt_q <= 1'b0;
            resume_q <= 1'b0;
            inject_q <= 1'b0;
            step_q <= 1'b0;
            replace_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            // request strobes last one cycle
            erase_q <= 1'b0;
            halt_q <= 1'b0;
            resume_q <= 1'b0;
            inject_q <= 1'b0;
            step_q <= 1'b0;
            replace_q <= 1'b0;
            brk_q <= 1'b0;
            case (state_q)
                ST_CMD: begin
                    if (link_fall) begin
                        rx_q <= rx_next;
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                        if (bit_cnt_q == 3'd7) begin
                            cmd_q <= rx_next;
                            args_left_q <= rx_next[`DCD_NARG_HI:`DCD_NARG_LO];
                            arg_q <= 24'h000000;
                            state_q <= (rx_next[1:0] == 2'b00) ? ST_EXEC : ST_ARG;
                        end
                    end
                end
                ST_ARG: begin
                    if (link_fall) begin
                        rx_q <= rx_next;
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                        if (bit_cnt_q == 3'd7) begin
                            // first host byte lands highest once all are in
                            arg_q <= {arg_q[15:0], rx_next};
                            args_left_q <= args_left_q - 2'd1;
                            if (args_left_q == 2'd1)
                                state_q <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    // commands other than status, erase and unknown codes close the erase window
                    // erase refused once disabled
                    if (op != `DCD_OP_STATUS && op != `DCD_OP_ERASE && op != `DCD_OP_NONE)
                        erase_allow_q <= 1'b0;
                    // unknown codes fall through every branch
                    if (lock_ok) begin
                        case (op)
                            `DCD_OP_ERASE: begin
                                erase_q <= erase_allow_q;
                            end
                            `DCD_OP_WRCFG: begin
                                cfg_q <= arg_q[3:0];
                            end
                            `DCD_OP_BRKPT: begin
                                brk_q <= 1'b1;
                            end
                            `DCD_OP_HALT: begin
                                halt_q <= 1'b1;
                            end
                            `DCD_OP_RESUME: begin
                                resume_q <= cpu_halted;
                            end
                            `DCD_OP_INJECT: begin
                                inject_q <= cpu_halted;
                            end
                            `DCD_OP_STEP: begin
                                step_q <= cpu_halted;
                            end
                            `DCD_OP_REPLACE: begin
                                replace_q <= cpu_halted;
                            end
                            default: begin
                            end
                        endcase
                    end
                    // reply selection; 16-bit replies ignore the return flag
                    if (op == `DCD_OP_PC && lock_ok) begin
                        tx_q <= cpu_pc;
                        ret_len_q <= `DCD_RET_WORD;
                    end else if (op == `DCD_OP_IDENT) begin
                        tx_q <= chip_identity;
                        ret_len_q <= `DCD_RET_WORD;
                    end else if (cmd_q[`DCD_RET_BIT]) begin
                        if (op == `DCD_OP_RDCFG && lock_ok)
                            tx_q <= {4'h0, cfg_q, 8'h00};
                        else
                            tx_q <= {status_byte, 8'h00}; // status reply
                        ret_len_q <= `DCD_RET_BYTE;
                    end else begin
                        ret_len_q <= 5'd0;
                    end
                    sent_q <= 5'd0;
                    bit_cnt_q <= 3'd0;
                    // a locked pc read sends nothing: waiting here would eat the next command's first fall
                    if (cmd_q[`DCD_RET_BIT] || (op == `DCD_OP_PC && lock_ok) || op == `DCD_OP_IDENT)
                        state_q <= ST_RET;
                    else
                        state_q <= ST_CMD;
                end
                ST_RET: begin
                    // msb first; pin held until host samples the last bit
                    if (link_rise && sent_q != ret_len_q) begin
                        out_q <= tx_q[15];
                        oe_q <= 1'b1;
                        tx_q <= {tx_q[14:0], 1'b0};
                        sent_q <= sent_q + 5'd1;
                    end else if (link_fall && sent_q == ret_len_q) begin
                        oe_q <= 1'b0;
                        out_q <= 1'b0;
                        state_q <= ST_CMD;
                    end
                end
                default: begin
                    state_q <= ST_CMD;
                end
            endcase
        end
    end

    assign dbg_data_out = out_q;
    assign dbg_data_oe = oe_q;
    assign erase_req = erase_q;
    assign halt_req = halt_q;
    assign resume_req = resume_q;
    assign inject_req = inject_q;
    assign step_req = step_q;
    assign replace_req = replace_q;
    assign breakpoint_req = brk_q;
    assign cmd_arg = arg_q;
    assign cmd_arg_count = cmd_q[1:0];

    assign timers_off = cfg_q[`DCD_CFG_TIMERS_OFF];
    assign dma_pause = cfg_q[`DCD_CFG_DMA_PAUSE];
    assign timer_suspend = cfg_q[`DCD_CFG_TIMER_SUSPEND];
    assign sel_info_page = cfg_q[`DCD_CFG_INFO_PAGE];

endmodule
`default_nettype wire

//--- hw/dcd_map.vh
// constants of the debug command decoder: command codes, field positions, reset values
// assumes plain verilog-2005 and inclusion by bare name
`ifndef DCD_MAP_VH
`define DCD_MAP_VH

// command byte fields
`define DCD_RET_BIT 2
`define DCD_NARG_HI 1
`define DCD_NARG_LO 0

// decoded operations
`define DCD_OP_NONE 4'h0
`define DCD_OP_ERASE 4'h1
`define DCD_OP_WRCFG 4'h2
`define DCD_OP_RDCFG 4'h3
`define DCD_OP_PC 4'h4
`define DCD_OP_STATUS 4'h5
`define DCD_OP_BRKPT 4'h6
`define DCD_OP_HALT 4'h7
`define DCD_OP_RESUME 4'h8
`define DCD_OP_INJECT 4'h9
`define DCD_OP_STEP 4'hA
`define DCD_OP_REPLACE 4'hB
`define DCD_OP_IDENT 4'hC

// command patterns: full bytes and masked prefixes
`define DCD_PAT_ERASE 5'h02
`define DCD_PAT_WRCFG 5'h03
`define DCD_PAT_STATUS 5'h06
`define DCD_PAT_BRKPT 5'h07
`define DCD_CODE_RDCFG 8'h24
`define DCD_CODE_PC 8'h28
`define DCD_CODE_HALT 8'h44
`define DCD_CODE_RESUME 8'h4C
`define DCD_CODE_STEP 8'h5C
`define DCD_CODE_IDENT 8'h68
`define DCD_PAT_INJECT 6'h15
`define DCD_PAT_REPLACE 6'h19

// configuration byte fields
`define DCD_CFG_TIMERS_OFF 3
`define DCD_CFG_DMA_PAUSE 2
`define DCD_CFG_TIMER_SUSPEND 1
`define DCD_CFG_INFO_PAGE 0
`define DCD_CFG_RESET 4'h0

// return lengths in bits
`define DCD_RET_BYTE 5'h08
`define DCD_RET_WORD 5'h10

`endif

//--- sim/dcd_debug_command_decoder_properties.sv
// checker for the debug command decoder ports
// assumes one clk_sys domain, bound onto the decoder
`timescale 1ns/1ps
`default_nettype none
module dcd_checker (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic dbg_clk,
    input wire logic dbg_data_out,
    input wire logic dbg_data_oe,
    input wire logic cpu_halted,
    input wire logic port_lock_bit,
    input wire logic erase_req,
    input wire logic halt_req,
    input wire logic resume_req,
    input wire logic inject_req,
    input wire logic step_req,
    input wire logic replace_req,
    input wire logic breakpoint_req,
    input wire logic [1:0] cmd_arg_count,
    input wire logic timers_off,
    input wire logic dma_pause,
    input wire logic timer_suspend,
    input wire logic sel_info_page
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic closed_q;
    wire logic any_cmd = halt_req | resume_req | inject_req | step_req | replace_req | breakpoint_req;
    wire logic [3:0] cfg = {timers_off, dma_pause, timer_suspend, sel_info_page};
    // erase window shut by any halt, resume, inject, step, replace or breakpoint strobe
    always @(posedge clk_sys) begin
        if (sys_rst)
            closed_q <= 1'b0;
        else if (any_cmd)
            closed_q <= 1'b1;
    end
    AST_ERASE_PULSE: assert property (erase_req |=> !erase_req) else $error("erase pulse too long");
    AST_ERASE_WINDOW: assert property (erase_req |-> !closed_q) else $error("erase after command");
    AST_HALT_PULSE: assert property ($rose(halt_req) |=> $fell(halt_req)) else $error("halt pulse bad");
    AST_RESUME_HALTED: assert property (resume_req |-> $past(cpu_halted)) else $error("resume while running");
    AST_INJECT_HALTED: assert property (inject_req |-> $past(cpu_halted)) else $error("inject running");
    AST_STEP_HALTED: assert property (step_req |-> $past(cpu_halted)) else $error("step running");
    AST_REPLACE_HALTED: assert property (replace_req |-> $past(cpu_halted)) else $error("replace running");
    AST_BRK_ARGS: assert property (breakpoint_req |-> cmd_arg_count == 2'h3) else $error("breakpoint args");
    AST_LOCK_BLOCKS: assert property (port_lock_bit |-> !any_cmd) else $error("command while locked");
    AST_CFG_LOCKED: assert property ($changed(cfg) |-> !$past(port_lock_bit)) else $error("config locked");
    AST_OUT_ON_RISE: assert property (dbg_data_oe && $past(dbg_data_oe) && $changed(dbg_data_out)
        |-> $past(dbg_clk)) else $error("reply bit moved off rise");
    AST_OE_OFF_ON_FALL: assert property ($fell(dbg_data_oe) |-> !$past(dbg_clk)) else $error("oe off early");
endmodule
bind dcd_debug_command_decoder dcd_checker dcd_checker_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .dbg_clk(dbg_clk), .dbg_data_out(dbg_data_out), .dbg_data_oe(dbg_data_oe), .cpu_halted(cpu_halted),
    .port_lock_bit(port_lock_bit), .erase_req(erase_req), .halt_req(halt_req), .resume_req(resume_req),
    .inject_req(inject_req), .step_req(step_req), .replace_req(replace_req),
    .breakpoint_req(breakpoint_req), .cmd_arg_count(cmd_arg_count), .timers_off(timers_off),
    .dma_pause(dma_pause), .timer_suspend(timer_suspend), .sel_info_page(sel_info_page));
`default_nettype wire

//--- sim/dcd_debug_command_decoder_tb_top.sv
// self-checking bench for the debug command decoder
// assumes the host model paces the link from clk_sys
`timescale 1ns/1ps
`default_nettype none
module dcd_debug_command_decoder_tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] st = 8'h02;
    logic [15:0] cpu_pc = 16'h0000;
    logic [15:0] chip_identity = 16'h0000;
    logic [7:0] rsp = 8'h00;
    logic [7:0] hc[8] = '{8'h4C, 8'h55, 8'h57, 8'h5C, 8'h64, 8'h66, 8'h3F, 8'h44};
    logic [7:0] lc[7] = '{8'h10, 8'h19, 8'h24, 8'h28, 8'h3B, 8'h68, 8'h34};
    wire dbg_clk, dbg_data_in, dbg_data_out, dbg_data_oe;
    wire timers_off, dma_pause, timer_suspend, sel_info_page;
    wire [6:0] strb;
    wire [23:0] cmd_arg;
    wire [1:0] cmd_arg_count;
    int num_errors = 0;
    int num_checks = 0;
    int pulses[7];
    int cfg_m = 0;
    bit erase_ok = 1'b1;
    always #50 clk_sys = ~clk_sys;
    dcd_debug_command_decoder dcd_debug_command_decoder_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .dbg_clk(dbg_clk), .dbg_data_in(dbg_data_in),
        .dbg_data_out(dbg_data_out), .dbg_data_oe(dbg_data_oe), .cpu_pc(cpu_pc), .chip_identity(chip_identity),
        .erase_done(st[7]), .cpu_idle(st[6]), .cpu_halted(st[5]), .power_mode_0(st[4]),
        .halt_cause(st[3]), .port_lock_bit(st[2]), .osc_stable(st[1]), .stack_overflow(st[0]),
        .erase_req(strb[0]), .halt_req(strb[1]), .resume_req(strb[2]), .inject_req(strb[3]),
        .step_req(strb[4]), .replace_req(strb[5]), .breakpoint_req(strb[6]), .cmd_arg(cmd_arg),
        .cmd_arg_count(cmd_arg_count), .timers_off(timers_off), .dma_pause(dma_pause),
        .timer_suspend(timer_suspend), .sel_info_page(sel_info_page));
    dcd_host_model dcd_host_model_inst (.clk_sys(clk_sys), .dbg_data_out(dbg_data_out),
        .dbg_data_oe(dbg_data_oe), .dbg_clk(dbg_clk), .dbg_data_in(dbg_data_in));
    // count strobe pulses of the running command
    always @(posedge clk_sys)
        for (int k = 0; k < 7; k++) if (strb[k] === 1'b1) pulses[k]++;
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one command through the model and the link; kind 0 keeps the erase window
    task automatic cmd(input logic [7:0] c, input logic [23:0] a);
        int op, nret, kind;
        logic [15:0] ex;
        logic [7:0] r;
        logic lk;
        lk = st[2];
        op = -1;
        kind = 2;
        nret = c[2];
        ex = {8'h00, st};
        a = a & ~(24'hFFFFFF << (8 * c[1:0]));
        casez (c)
            8'b0001_0?00: begin kind = 0; op = erase_ok ? 0 : -1; end
            8'b0011_0?00: kind = 0;
            8'b0001_1?01: if (!lk) cfg_m = a[3:0];
            8'h24: if (!lk) ex = cfg_m;
            8'h28: if (!lk) begin nret = 2; ex = cpu_pc; end
            8'h68: begin nret = 2; ex = chip_identity; end
            8'b0011_1?11: op = 6;
            8'h44: op = 1;
            8'h4C: op = st[5] ? 2 : -1;
            8'b0101_01??: op = st[5] ? 3 : -1;
            8'h5C: op = st[5] ? 4 : -1;
            8'b0110_01??: op = st[5] ? 5 : -1;
            default: kind = 1; // unknown code still answers the status byte when bit 2 asks
        endcase
        if (lk && op > 0) op = -1;
        if (kind == 2) erase_ok = 1'b0;
        pulses = '{default: 0};
        dcd_host_model_inst.put_byte(c);
        for (int i = int'(c[1:0]) - 1; i >= 0; i--) dcd_host_model_inst.put_byte(a[8*i +: 8]);
        for (int j = nret - 1; j >= 0; j--) begin
            dcd_host_model_inst.get_byte(r);
            rsp = r;
            check(r, ex[8*j +: 8], "reply");
        end
        repeat (8) @(posedge clk_sys);
        #5;
        for (int k = 0; k < 7; k++) check(pulses[k], k == op, "strobe");
        check({timers_off, dma_pause, timer_suspend, sel_info_page}, cfg_m, "config");
        if (op >= 0) check({cmd_arg_count, cmd_arg}, {c[1:0], a}, "args");
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // main sequence: status, erase, config, reads, halt group, locked port
    initial begin
        void'($urandom(32'h8413));
        repeat (6) @(posedge clk_sys);
        #5 sys_rst = 1'b0;
        st = ($urandom() & 8'hDB) | 8'h02;
        for (int n = 0; n < 4 && rsp[1] !== 1'b1; n++) cmd(8'h34, 0);
        cmd(8'h30, 0);
        cmd(8'h10, 0);
        st[7] = 1'b1;
        rsp = 8'h00;
        for (int n = 0; n < 4 && rsp[7] !== 1'b1; n++) cmd(8'h34, 0);
        cmd(8'h14, 0);
        for (int i = 0; i < 6; i++) begin
            cmd(i[0] ? 8'h1D : 8'h19, $urandom());
            cmd(8'h24, 0);
        end
        cmd(8'h10, 0);
        cpu_pc = $urandom();
        chip_identity = $urandom();
        cmd(8'h28, 0);
        cmd(8'h68, 0);
        cmd(8'h00, 0);
        cmd(8'h7C, 0);
        // first pass running on purpose, then halted
        for (int h = 0; h < 2; h++) begin
            st[5] = h[0];
            foreach (hc[k]) cmd(hc[k], $urandom());
        end
        // second reset mid-run, port now locked
        sys_rst = 1'b1;
        st[2] = 1'b1;
        cfg_m = 0;
        erase_ok = 1'b1;
        repeat (3) @(posedge clk_sys);
        #5 sys_rst = 1'b0;
        repeat (3) @(posedge clk_sys);
        #5;
        foreach (lc[k]) cmd(lc[k], $urandom());
        give_verdict();
    end
    // watchdog: the whole run needs well under 20k cycles
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire

//--- sim/dcd_host_model.sv
// host model: drives the two-wire debug link, bit by bit
// assumes clk_sys paces the link, 4 cycles per half period
`timescale 1ns/1ps
`default_nettype none
module dcd_host_model (
    input wire logic clk_sys,
    input wire logic dbg_data_out,
    input wire logic dbg_data_oe,
    output logic dbg_clk,
    output wire logic dbg_data_in
);
    logic host_d = 1'b0;
    initial dbg_clk = 1'b0;
    // wire level: device wins while it drives
    assign dbg_data_in = dbg_data_oe ? dbg_data_out : host_d;
    task automatic half();
        repeat (4) @(posedge clk_sys);
        #5;
    endtask
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            half();
            dbg_clk = 1'b1;
            host_d = b[i];
            half();
            dbg_clk = 1'b0;
        end
    endtask
    // released line toggles, so a stale level cannot pass
    task automatic get_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            half();
            dbg_clk = 1'b1;
            host_d = ~host_d;
            half();
            b[i] = dbg_data_in;
            dbg_clk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire
